// ---- logic/input_cmd_regs.svh ----
// Constants for the drive input terminal command decoder.
// Included by the package user modules; definitions only.
`ifndef INPUT_CMD_REGS_SVH
`define INPUT_CMD_REGS_SVH

// Terminal count and function code layout
`define N_TERM 5
`define CODE_W 11
`define NEG_LOGIC_OFS 11'h3e8
// Function codes
`define FC_RAMP_SET 11'h004
`define FC_THREE_WIRE 11'h006
`define FC_COAST 11'h007
`define FC_ALARM_CLR 11'h008
`define FC_EXT_TRIP 11'h009
`define FC_INCH 11'h00a
`define FC_FREQ_SRC 11'h00b
`define FC_WRITE_EN 11'h013
`define FC_LOOP_EN 11'h014
`define FC_INVERT 11'h015
`define FC_LINK_PRI 11'h018
`define FC_ACCUM_CLR 11'h021
`define FC_INT_FREEZE 11'h022
`define FC_RUN_FWD 11'h062
`define FC_RUN_BWD 11'h063
// Run source: 1 is terminals, other values keypad
`define RUN_SRC_TERMINAL 2'h1
// Alarm clear minimum hold time
`define ALARM_CLR_MS 10
`define CLK_KHZ 40000
`define ALARM_CLR_CYC (`ALARM_CLR_MS * `CLK_KHZ)
`define ALARM_CNT_W 19
// Reset value of the default-on commands when unassigned
`define CMD_RESET 16'h0000

`endif

// ---- logic/input_cmd_pkg.sv ----
// Types shared by the input terminal command decoder.
// Assumes the constants header is available for include.
package input_cmd_pkg;
  typedef enum logic [1:0] {ALM_IDLE, ALM_ACTIVE, ALM_CLEARING} alarm_state_t;
  typedef enum logic [1:0] {RUN_STOP, RUN_FWD, RUN_BWD} run_dir_t;
endpackage

// ---- logic/term_sync.sv ----
// Two-stage synchroniser with polarity correction for one terminal.
// Assumes the raw level may change at any time relative to i_clk.
`timescale 1ns/10ps
`include "input_cmd_regs.svh"
module term_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Terminal
  input wire logic i_raw,
  input wire logic i_neg_logic,
  output logic o_level
);
  logic meta_reg;
  logic sync_reg;

  // First stage is read only by the second stage
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (i_ce) begin
      meta_reg <= i_raw;
      sync_reg <= meta_reg;
    end
  end

  // Negative logic makes the open terminal active
  assign o_level = sync_reg ^ i_neg_logic;
endmodule

// ---- logic/drive_input_command_decoder.sv ----
// Decoder of programmable digital input terminal commands for a drive.
// Assumes terminals are sampled on i_clk and configuration is static.
`timescale 1ns/10ps
`include "input_cmd_regs.svh"
module drive_input_command_decoder
  import input_cmd_pkg::*;
#(
  parameter int ALARM_CLR_CYCLES = `ALARM_CLR_CYC
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Input terminals and their function codes
  input wire logic [`N_TERM-1:0] i_term,
  input wire logic [`N_TERM*`CODE_W-1:0] i_term_code,
  // Configuration from the control core
  input wire logic [1:0] i_run_source_code,
  input wire logic i_data_protect_code,
  input wire logic i_loop_polarity_code,
  input wire logic i_edit_target_is_protect,
  // Control core status and keypad
  input wire logic i_protect_trip,
  input wire logic i_motor_running,
  input wire logic i_inch_key_combo,
  // Drive commands
  output logic o_run_forward,
  output logic o_run_backward,
  output logic o_output_cut,
  output logic o_ramp_set_two,
  output logic o_inch_active,
  output logic o_use_inch_setting,
  output logic o_freq_source_two,
  output logic o_edit_allowed,
  output logic o_loop_enable,
  output logic o_inverse_ctrl,
  output logic o_loop_inverse,
  output logic o_link_priority,
  output logic o_loop_accum_clear,
  output logic o_integral_freeze,
  // Alarm status
  output logic o_alarm_active,
  output logic o_alarm_output,
  output logic o_external_alarm_code
);
  logic [`N_TERM-1:0] level;
  logic [`CODE_W-1:0] code [`N_TERM];
  logic [`CODE_W-1:0] func [`N_TERM];
  logic [`N_TERM-1:0] neg;

  // Per-terminal synchroniser and code split
  genvar g;
  generate
    for (g = 0; g < `N_TERM; g++) begin : g_term
      assign code[g] = i_term_code[g*`CODE_W +: `CODE_W];
      assign neg[g] = (code[g] >= `NEG_LOGIC_OFS);
      assign func[g] = neg[g] ? code[g] - `NEG_LOGIC_OFS : code[g];
      term_sync u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_raw(i_term[g]),
        .i_neg_logic(neg[g]),
        .o_level(level[g])
      );
    end
  endgenerate

  // Gather command levels by function; OR over terminals
  logic c_ramp, c_hold, c_coast, c_clr, c_trip, c_inch, c_fsrc;
  logic c_we, c_loop, c_inv, c_link, c_accum, c_freeze, c_fwd, c_bwd;
  logic a_hold, a_trip, a_we, a_link;
  always_comb begin
    c_ramp = 1'b0;
    c_hold = 1'b0;
    c_coast = 1'b0;
    c_clr = 1'b0;
    c_trip = 1'b0;
    c_inch = 1'b0;
    c_fsrc = 1'b0;
    c_we = 1'b0;
    c_loop = 1'b0;
    c_inv = 1'b0;
    c_link = 1'b0;
    c_accum = 1'b0;
    c_freeze = 1'b0;
    c_fwd = 1'b0;
    c_bwd = 1'b0;
    a_hold = 1'b0;
    a_trip = 1'b0;
    a_we = 1'b0;
    a_link = 1'b0;
    for (int i = 0; i < `N_TERM; i++) begin
      case (func[i])
        `FC_RAMP_SET: c_ramp = c_ramp | level[i];
        `FC_THREE_WIRE: begin
          c_hold = c_hold | level[i];
          a_hold = 1'b1;
        end
        `FC_COAST: c_coast = c_coast | level[i];
        `FC_ALARM_CLR: c_clr = c_clr | level[i];
        `FC_EXT_TRIP: begin
          c_trip = c_trip | level[i];
          a_trip = 1'b1;
        end
        `FC_INCH: c_inch = c_inch | level[i];
        `FC_FREQ_SRC: c_fsrc = c_fsrc | level[i];
        `FC_WRITE_EN: begin
          c_we = c_we | level[i];
          a_we = 1'b1;
        end
        `FC_LOOP_EN: c_loop = c_loop | level[i];
        `FC_INVERT: c_inv = c_inv | level[i];
        `FC_LINK_PRI: begin
          c_link = c_link | level[i];
          a_link = 1'b1;
        end
        `FC_ACCUM_CLR: c_accum = c_accum | level[i];
        `FC_INT_FREEZE: c_freeze = c_freeze | level[i];
        `FC_RUN_FWD: c_fwd = c_fwd | level[i];
        `FC_RUN_BWD: c_bwd = c_bwd | level[i];
        default: ;
      endcase
    end
  end

  // Run direction: latched in three-wire mode, direct in two-wire mode
  run_dir_t run_reg;
  run_dir_t run_next;
  always_comb begin
    run_next = run_reg;
    if (!a_hold) begin
      if (c_fwd && !c_bwd)
        run_next = RUN_FWD;
      else if (c_bwd && !c_fwd)
        run_next = RUN_BWD;
      else
        run_next = RUN_STOP;
    end else if (!c_hold) begin
      run_next = RUN_STOP;
    end else begin
      case (run_reg)
        RUN_STOP: begin
          if (c_fwd && !c_bwd)
            run_next = RUN_FWD;
          else if (c_bwd && !c_fwd)
            run_next = RUN_BWD;
        end
        RUN_FWD: run_next = RUN_FWD;
        RUN_BWD: run_next = RUN_BWD;
        default: run_next = RUN_STOP;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      run_reg <= RUN_STOP;
    else if (i_ce)
      run_reg <= run_next;
  end

  // Alarm sequence; clear must be held the minimum time to count
  alarm_state_t alm_reg;
  logic [`ALARM_CNT_W-1:0] clr_cnt_reg;
  logic ext_code_reg;
  logic trip_event;
  logic clr_held;
  assign trip_event = a_trip && !c_trip && i_motor_running;
  assign clr_held = (clr_cnt_reg >=
                     `ALARM_CNT_W'(ALARM_CLR_CYCLES));

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      clr_cnt_reg <= '0;
    else if (i_ce) begin
      if (!c_clr || alm_reg == ALM_IDLE)
        clr_cnt_reg <= '0;
      else if (!clr_held)
        clr_cnt_reg <= clr_cnt_reg + `ALARM_CNT_W'(1);
    end
  end

  // New external trips win over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      alm_reg <= ALM_IDLE;
      ext_code_reg <= 1'b0;
    end else if (i_ce) begin
      case (alm_reg)
        ALM_IDLE: begin
          if (trip_event || i_protect_trip)
            alm_reg <= ALM_ACTIVE;
          if (trip_event)
            ext_code_reg <= 1'b1;
        end
        ALM_ACTIVE: begin
          if (trip_event)
            ext_code_reg <= 1'b1;
          else if (clr_held)
            alm_reg <= ALM_CLEARING;
        end
        ALM_CLEARING: begin
          if (trip_event || i_protect_trip) begin
            alm_reg <= ALM_ACTIVE;
            ext_code_reg <= ext_code_reg | trip_event;
          end else if (!c_clr) begin
            alm_reg <= ALM_IDLE;
            ext_code_reg <= 1'b0;
          end
        end
        default: alm_reg <= ALM_IDLE;
      endcase
    end
  end

  // Jog toggle from the keypad combination
  logic kp_mode;
  logic jog_toggle_reg;
  assign kp_mode = (i_run_source_code != `RUN_SRC_TERMINAL);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn)
      jog_toggle_reg <= 1'b0;
    else if (i_ce) begin
      if (!kp_mode || c_inch)
        jog_toggle_reg <= 1'b0;
      else if (i_inch_key_combo)
        jog_toggle_reg <= !jog_toggle_reg;
    end
  end

  // Registered command outputs
  logic inch_now;
  logic we_now;
  assign inch_now = c_inch || jog_toggle_reg;
  assign we_now = a_we ? c_we : 1'b1;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_run_forward <= 1'b0;
      o_run_backward <= 1'b0;
      o_output_cut <= 1'b0;
      o_ramp_set_two <= 1'b0;
      o_inch_active <= 1'b0;
      o_use_inch_setting <= 1'b0;
      o_freq_source_two <= 1'b0;
      o_edit_allowed <= 1'b0;
      o_loop_enable <= 1'b0;
      o_inverse_ctrl <= 1'b0;
      o_loop_inverse <= 1'b0;
      o_link_priority <= 1'b0;
      o_loop_accum_clear <= 1'b0;
      o_integral_freeze <= 1'b0;
      o_alarm_active <= 1'b0;
      o_alarm_output <= 1'b0;
      o_external_alarm_code <= 1'b0;
    end else if (i_ce) begin
      o_run_forward <= (run_next == RUN_FWD);
      o_run_backward <= (run_next == RUN_BWD);
      o_output_cut <= c_coast || trip_event ||
                      (alm_reg != ALM_IDLE);
      o_ramp_set_two <= c_ramp;
      o_inch_active <= inch_now;
      o_use_inch_setting <= inch_now;
      o_freq_source_two <= c_fsrc;
      o_edit_allowed <= we_now && (!i_data_protect_code ||
                        i_edit_target_is_protect);
      o_loop_enable <= c_loop;
      o_inverse_ctrl <= c_inv;
      o_loop_inverse <= i_loop_polarity_code ^ c_inv;
      o_link_priority <= a_link ? c_link : 1'b1;
      o_loop_accum_clear <= c_accum;
      o_integral_freeze <= c_freeze;
      o_alarm_active <= (alm_reg != ALM_IDLE) || trip_event;
      o_alarm_output <= (alm_reg == ALM_ACTIVE) || trip_event;
      o_external_alarm_code <= ext_code_reg || trip_event;
    end
  end
endmodule

// ---- test/input_cmd_checker.sv ----
// Port checker for the input terminal command decoder.
// Assumes codes change only under reset; a low i_ce restarts settling.
`timescale 1ns/10ps
`include "input_cmd_regs.svh"
module input_cmd_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  // Terminals and configuration
  input wire logic [`N_TERM-1:0] i_term,
  input wire logic [`N_TERM*`CODE_W-1:0] i_term_code,
  input wire logic i_data_protect_code,
  input wire logic i_loop_polarity_code,
  input wire logic i_edit_target_is_protect,
  input wire logic i_motor_running,
  // Watched outputs
  input wire logic o_run_forward,
  input wire logic o_run_backward,
  input wire logic o_output_cut,
  input wire logic o_ramp_set_two,
  input wire logic o_freq_source_two,
  input wire logic o_edit_allowed,
  input wire logic o_inverse_ctrl,
  input wire logic o_loop_inverse,
  input wire logic o_link_priority,
  input wire logic o_alarm_output,
  input wire logic o_external_alarm_code
);
  logic [2:0] up_cnt;
  logic up, has_latch, has_we, has_lp;
  logic [10:0] fn;
  wire [10:0] c0 = i_term_code[10:0];
  wire [10:0] c1 = i_term_code[21:11];
  wire [10:0] c3 = i_term_code[43:33];
  wire [10:0] c4 = i_term_code[54:44];
  // Settled once the sync pipe holds only post-reset samples
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) up_cnt <= 3'h0;
    else if (!i_ce) up_cnt <= 3'h0; // Frozen cycles break the $past window
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  assign up = up_cnt >= 3'h4;
  // Which default-on or mode functions have a terminal
  always_comb begin
    has_latch = 1'h0;
    has_we = 1'h0;
    has_lp = 1'h0;
    for (int k = 0; k < 5; k++) begin
      fn = i_term_code[11*k +: 11];
      if (fn >= `NEG_LOGIC_OFS) fn = fn - `NEG_LOGIC_OFS;
      has_latch |= fn == `FC_THREE_WIRE;
      has_we |= fn == `FC_WRITE_EN;
      has_lp |= fn == `FC_LINK_PRI;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence trip_open_s;
    up && c1 == `FC_EXT_TRIP && i_motor_running && $fell(i_term[1]);
  endsequence
  sequence alarm_shown_s;
    o_output_cut && o_alarm_output && o_external_alarm_code;
  endsequence
  AST_EXT_TRIP: assert property (trip_open_s |-> ##3 alarm_shown_s)
    else $error("trip not shown");
  AST_RAMP_SEL: assert property (up && c0 == `FC_RAMP_SET |->
    o_ramp_set_two == $past(i_term[0], 3)) else $error("ramp select");
  AST_NEG_SENSE: assert property (
    up && c0 == `FC_RAMP_SET + `NEG_LOGIC_OFS |->
    o_ramp_set_two != $past(i_term[0], 3)) else $error("negative sense");
  AST_FREQ_SRC: assert property (up && c0 == `FC_FREQ_SRC |->
    o_freq_source_two == $past(i_term[0], 3)) else $error("freq source");
  AST_COAST: assert property (up && c0 == `FC_COAST &&
    $past(i_term[0], 3) |-> o_output_cut) else $error("coast");
  AST_TWO_WIRE: assert property (
    up && c3 == `FC_RUN_FWD && c4 == `FC_RUN_BWD && !has_latch
    && !o_output_cut |-> {o_run_backward, o_run_forward} ==
    {$past(i_term[4], 3) && !$past(i_term[3], 3),
    $past(i_term[3], 3) && !$past(i_term[4], 3)}) else $error("two wire");
  AST_WE_DEFAULT: assert property (up && !has_we |->
    o_edit_allowed == (!$past(i_data_protect_code) ||
    $past(i_edit_target_is_protect))) else $error("edit default");
  AST_LINK_DEFAULT: assert property (up && !has_lp |->
    o_link_priority) else $error("link default");
  AST_LOOP_SENSE: assert property (up |-> o_loop_inverse ==
    (o_inverse_ctrl ^ $past(i_loop_polarity_code))) else $error("sense");
  AST_FREEZE: assert property (!i_ce |=> $stable({o_run_forward,
    o_run_backward, o_output_cut, o_ramp_set_two, o_freq_source_two,
    o_edit_allowed, o_link_priority, o_alarm_output})) else $error("freeze");
endmodule
bind drive_input_command_decoder input_cmd_checker i_input_cmd_checker (.*);

// ---- test/switch_panel.sv ----
// Contact model of the switches wired to the input terminals.
// Assumes the bench sets contacts just after a clock edge.
`timescale 1ns/10ps
module switch_panel #(
  parameter int HOLD = 8
) (
  // Clock
  input wire logic i_clk,
  // Contacts, 1 is closed; lax allows a too-short clear press
  input wire logic [4:0] i_close,
  input wire logic i_lax,
  // Raw terminal levels
  output logic [4:0] o_term
);
  logic [7:0] hold_cnt = 8'h0;
  logic last = 1'h0;
  // A clear press is stretched so the drive can accept it, except while lax is set
  always_ff @(posedge i_clk) begin
    last <= i_close[2];
    if (i_close[2] && !last && !i_lax) hold_cnt <= 8'(HOLD);
    else if (hold_cnt != 8'h0) hold_cnt <= hold_cnt - 8'h1;
  end
  assign o_term = {i_close[4:3], i_close[2] | (hold_cnt != 8'h0),
    i_close[1:0]};
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the input terminal command decoder.
// Assumes the switch panel model drives the terminal pins.
`timescale 1ns/10ps
`include "input_cmd_regs.svh"
module tb;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_ce = 1'h1, lax = 1'h0;
  logic [4:0] i_term, close = 5'h0;
  logic [54:0] i_term_code = 55'h0;
  logic [1:0] i_run_source_code = 2'h0;
  logic i_data_protect_code = 1'h0, i_loop_polarity_code = 1'h0;
  logic i_edit_target_is_protect = 1'h0, i_protect_trip = 1'h0;
  logic i_motor_running = 1'h0, i_inch_key_combo = 1'h0;
  logic o_run_forward, o_run_backward, o_output_cut, o_ramp_set_two;
  logic o_inch_active, o_use_inch_setting, o_freq_source_two;
  logic o_edit_allowed, o_loop_enable, o_inverse_ctrl, o_loop_inverse;
  logic o_link_priority, o_loop_accum_clear, o_integral_freeze;
  logic o_alarm_active, o_alarm_output, o_external_alarm_code;
  int fails = 0, compares = 0;
  always #12.5 i_clk = ~i_clk;
  // Short clear hold keeps the alarm scenario brief
  drive_input_command_decoder #(.ALARM_CLR_CYCLES(8))
    i_drive_input_command_decoder (.*);
  switch_panel #(.HOLD(10)) i_switch_panel (.i_clk(i_clk),
    .i_close(close), .i_lax(lax), .o_term(i_term));
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Codes are static, so they change only under reset
  task automatic cfg(input logic [54:0] codes);
    i_resetn = 1'h0;
    close = 5'h0;
    i_term_code = codes;
    step(2);
    i_resetn = 1'h1;
    step(4);
  endtask
  task automatic t_levels();
    logic [10:0] fc [9] = '{`FC_RAMP_SET, `FC_FREQ_SRC, `FC_LOOP_EN,
      `FC_INVERT, `FC_ACCUM_CLR, `FC_INT_FREEZE, `FC_INCH, `FC_LINK_PRI,
      `FC_WRITE_EN};
    logic [8:0] lv;
    for (int n = 0; n < 2; n++) begin
      i_loop_polarity_code = n[0];
      for (int i = 0; i < 9; i++) begin
        cfg({44'h0, fc[i] + (n[0] ? `NEG_LOGIC_OFS : 11'h0)});
        for (int c = 0; c < 2; c++) begin
          close[0] = c[0];
          step(4);
          lv = {o_edit_allowed, o_link_priority, o_inch_active,
            o_integral_freeze, o_loop_accum_clear, o_inverse_ctrl,
            o_loop_enable, o_freq_source_two, o_ramp_set_two};
          chk(lv[i], c[0] ^ n[0]);
        end
      end
    end
    $display("levels done");
  endtask
  task automatic t_run();
    logic [1:0] pat [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    cfg({`FC_RUN_BWD, `FC_RUN_FWD, 33'h0});
    foreach (pat[i]) begin
      close[4:3] = pat[i];
      step(4);
      chk({o_run_backward, o_run_forward},
        pat[i] == 2'h3 ? 2'h0 : pat[i]);
    end
    cfg({`FC_RUN_BWD, `FC_RUN_FWD, 22'h0, `FC_THREE_WIRE});
    close = 5'h9;
    step(2);
    close[3] = 1'h0;
    step(4);
    chk(o_run_forward, 1'h1);
    close[0] = 1'h0;
    step(4);
    chk(o_run_forward, 1'h0);
    $display("run done");
  endtask
  task automatic t_alarm();
    cfg({22'h0, `FC_ALARM_CLR, `FC_EXT_TRIP, `FC_COAST});
    close = 5'h3; // clear contact stays open while running
    step(3);
    i_motor_running = 1'h1; // Trip contact already seen closed
    step(2);
    chk({o_alarm_active, o_output_cut}, 2'h1);
    close = 5'h0;
    step(4);
    chk({o_external_alarm_code, o_alarm_output, o_alarm_active,
      o_output_cut}, 4'hf);
    lax = 1'h1;
    close = 5'h6;
    step(3);
    close[2] = 1'h0;
    lax = 1'h0;
    step(4);
    chk(o_alarm_output, 1'h1);
    close[2] = 1'h1;
    step(14);
    chk({o_alarm_active, o_alarm_output}, 2'h2);
    close[2] = 1'h0;
    step(12);
    chk({o_external_alarm_code, o_alarm_active, o_output_cut}, 3'h0);
    i_motor_running = 1'h0;
    // Other protection also enters alarm, without the external code
    i_protect_trip = 1'h1;
    step(1);
    i_protect_trip = 1'h0;
    step(2);
    chk({o_external_alarm_code, o_alarm_output, o_alarm_active}, 3'h3);
    $display("alarm done");
  endtask
  task automatic t_freeze();
    cfg({44'h0, `FC_RAMP_SET});
    i_ce = 1'h0;
    close[0] = 1'h1;
    step(6);
    chk(o_ramp_set_two, 1'h0);
    i_ce = 1'h1;
    step(4);
    chk(o_ramp_set_two, 1'h1);
    $display("freeze done");
  endtask
  task automatic t_edit();
    cfg({44'h0, `FC_WRITE_EN});
    for (int i = 0; i < 8; i++) begin
      {close[0], i_data_protect_code, i_edit_target_is_protect} = i[2:0];
      step(4);
      chk(o_edit_allowed, i[2] && (!i[1] || i[0]));
    end
    cfg(55'h0);
    chk({o_link_priority, o_edit_allowed}, 2'h3);
    $display("edit done");
  endtask
  task automatic t_key();
    cfg({44'h0, `FC_INCH});
    for (int i = 0; i < 5; i++) begin
      i_run_source_code = i == 2 ? `RUN_SRC_TERMINAL : 2'h0;
      close[0] = i == 3;
      step(2);
      i_inch_key_combo = i != 4;
      step(1);
      i_inch_key_combo = 1'h0;
      step(4);
      chk({o_use_inch_setting, o_inch_active},
        (i == 0 || i == 3) ? 2'h3 : 2'h0);
    end
    $display("key done");
  endtask
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    step(20000);
    fails++;
    print_verdict();
  end
  initial begin
    step(10);
    i_resetn = 1'h1;
    t_levels();
    t_run();
    t_alarm();
    t_edit();
    t_key();
    t_freeze();
    print_verdict();
  end
endmodule
